// >>> verilog/supervisor_pkg.sv
// Package for the supply supervisor mode control block.
// Assumes a single 200 MHz clock and a synchronous active-low reset.
package supervisor_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int ClockPeriodPs = 5000;
  localparam int FastSettleNs = 2000;
  localparam int SlowSettleUs = 150;
  localparam int FastSettleCycles = FastSettleNs * 1000 / ClockPeriodPs;
  localparam int SlowSettleCycles = SlowSettleUs * 1000000 / ClockPeriodPs;
  localparam int SettleCountWidth = 16;
  localparam int ExcursionNs = 6000;
  localparam int ExcursionCycles = ExcursionNs * 1000 / ClockPeriodPs;

  // ==========================================================================
  // Unit operating states
  // ==========================================================================
  typedef enum logic [1:0] {
    UNIT_OFF = 2'h0,
    UNIT_NORMAL = 2'h1,
    UNIT_FULL = 2'h2
  } unit_state_t;

  // One side's control settings as software writes them.
  typedef struct packed {
    logic supervisorEnable;
    logic supervisorLpmKeep;
    logic supervisorFullPerf;
    logic monitorEnable;
    logic monitorFullPerf;
    logic autoControl;
  } side_control_t;

  // Resolved states of one side's supervisor and monitor.
  typedef struct packed {
    unit_state_t supervisorActive;
    unit_state_t supervisorDeep;
    unit_state_t monitorActive;
    unit_state_t monitorDeep;
  } side_states_t;

endpackage

// >>> verilog/settle_timer.sv
// Settling-delay timer for one supervisor side.
// Assumes the write strobe is a one-cycle pulse on the same clock.
`timescale 1ns/100ps
module settle_timer
  import supervisor_pkg::*;
#(
  parameter int SlowCycles = SlowSettleCycles,
  parameter int FastCycles = FastSettleCycles
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic controlWrite,
  input wire logic fullPerf,
  // Status
  output logic settleFlag
);

  logic [SettleCountWidth-1:0] count;
  logic [SettleCountWidth-1:0] next_count;
  logic next_settleFlag;

  // ==========================================================================
  // Countdown
  // ==========================================================================
  always_comb begin
    next_count = count;
    next_settleFlag = settleFlag;
    if (controlWrite) begin
      // A fresh write restarts the delay and wins over expiry.
      next_settleFlag = 1'b1; // RL17
      if (fullPerf) begin
        next_count = SettleCountWidth'(FastCycles - 1); // RL8
      end else begin
        next_count = SettleCountWidth'(SlowCycles - 1); // RL9
      end
    end else if (settleFlag) begin
      if (count == '0) begin
        next_settleFlag = 1'b0; // RL17
      end else begin
        next_count = count - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count <= '0;
      settleFlag <= 1'b0;
    end else begin
      count <= next_count;
      settleFlag <= next_settleFlag;
    end
  end

  a_flag_set_on_write: assert property (@(posedge clk) disable iff (!rst_n)
    controlWrite |=> settleFlag) else $error("flag not set by write"); // RL17

  a_fast_delay_length: assert property (@(posedge clk) disable iff (!rst_n)
    (controlWrite && fullPerf) ##1 (!controlWrite)[*8]
    |-> settleFlag) else $error("fast delay ended early"); // RL8

endmodule // settle_timer

// >>> verilog/supply_supervisor_mode_control.sv
// Mode control for low-side and high-side supply supervisors and monitors.
// Assumes software drives the control bits as plain ports on this clock,
// with one-cycle write strobes, and that deep sleep requests come from
// the same clock domain.
//
// Notes on behaviour
// (RL1) Manual low supervisor: keep bit selects keep-or-off.
// (RL2) Auto low supervisor: normal only if all bits.
// (RL3) Manual low monitor keeps its active state.
// (RL4) Auto low monitor: full-perf gives normal, else off.
// (RL5) Slow wake when enabled low-side unit not full-perf.
// (RL6) High supervisor mirrors low supervisor mapping.
// (RL7) High monitor: manual keeps, auto full-perf gives normal.
// (RL8) Full-performance settling delay about two microseconds.
// (RL9) Normal-mode settling delay about 150 microseconds.
// (RL10) Software raises core level only in normal mode.
// (RL11) Software waits for both settle flags before sleep.
// (RL12) Software halves main clock before deep sleep.
// (RL13) Software waits level-dependent cycles before full speed.
// (RL14) Subsystem clock from oscillator not masked on deep sleep exit.
// (RL15) Software keeps subsystem clock request enabled.
// (RL16) Power-up clear releases stuck wake-up condition.
// (RL17) Settle flag set on write, cleared after delay.
`timescale 1ns/100ps
module supply_supervisor_mode_control
  import supervisor_pkg::*;
#(
  parameter int SlowCycles = SlowSettleCycles,
  parameter int FastCycles = FastSettleCycles
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Power-up clear request, such as from the watchdog
  input wire logic powerUpClear,
  // Control settings and their write strobes
  input wire side_control_t lowControl,
  input wire side_control_t highControl,
  input wire logic lowControlWrite,
  input wire logic highControlWrite,
  // Power mode
  input wire logic deepSleep,
  input wire logic wakeRequest,
  input wire logic subsystemClockFromOscillator,
  // Resolved unit states
  output side_states_t lowStates,
  output side_states_t highStates,
  // Wake-up class, settling status, sleep state and subsystem clock unmask
  output logic slowWakeup,
  output logic lowSettleFlag,
  output logic highSettleFlag,
  output logic deepSleepActive,
  output logic subsystemClockUnmasked
);

  // ==========================================================================
  // Mode mapping
  // ==========================================================================
  function automatic unit_state_t active_state(input logic en,
                                               input logic fp);
    if (!en) begin
      return UNIT_OFF;
    end
    return fp ? UNIT_FULL : UNIT_NORMAL;
  endfunction

  function automatic side_states_t map_side(input side_control_t c);
    side_states_t s;
    s.supervisorActive = active_state(c.supervisorEnable,
                                      c.supervisorFullPerf);
    s.monitorActive = active_state(c.monitorEnable, c.monitorFullPerf);
    if (!c.supervisorLpmKeep || !c.supervisorEnable) begin
      s.supervisorDeep = UNIT_OFF; // RL1 RL6
    end else if (!c.autoControl) begin
      s.supervisorDeep = s.supervisorActive; // RL1 RL6
    end else begin
      s.supervisorDeep = c.supervisorFullPerf ? UNIT_NORMAL : UNIT_OFF; // RL2
    end
    if (!c.monitorEnable) begin
      s.monitorDeep = UNIT_OFF;
    end else if (!c.autoControl) begin
      s.monitorDeep = s.monitorActive; // RL3 RL7
    end else begin
      s.monitorDeep = c.monitorFullPerf ? UNIT_NORMAL : UNIT_OFF; // RL4 RL7
    end
    return s;
  endfunction

  side_states_t next_lowStates;
  side_states_t next_highStates;
  logic next_slowWakeup;

  always_comb begin
    next_lowStates = map_side(lowControl);
    next_highStates = map_side(highControl);
    next_slowWakeup =
      (lowControl.supervisorEnable && !lowControl.supervisorFullPerf) ||
      (lowControl.monitorEnable && !lowControl.monitorFullPerf); // RL5
  end

  always_ff @(posedge clk) begin
    if (!rst_n || powerUpClear) begin
      lowStates <= '0;
      highStates <= '0;
      slowWakeup <= 1'b0;
    end else begin
      lowStates <= next_lowStates;
      highStates <= next_highStates;
      slowWakeup <= next_slowWakeup;
    end
  end

  // ==========================================================================
  // Settling delays
  // ==========================================================================
  settle_timer #(
    .SlowCycles(SlowCycles),
    .FastCycles(FastCycles)
  ) lowTimer (
    .clk(clk),
    .rst_n(rst_n),
    .controlWrite(lowControlWrite),
    .fullPerf(lowControl.supervisorFullPerf),
    .settleFlag(lowSettleFlag)
  );

  settle_timer #(
    .SlowCycles(SlowCycles),
    .FastCycles(FastCycles)
  ) highTimer (
    .clk(clk),
    .rst_n(rst_n),
    .controlWrite(highControlWrite),
    .fullPerf(highControl.supervisorFullPerf),
    .settleFlag(highSettleFlag)
  );

  // ==========================================================================
  // Sleep state and clock excursion window
  // ==========================================================================
  typedef enum logic [2:0] {
    PM_ACTIVE = 3'h1,
    PM_SLEEP = 3'h2,
    PM_EXIT = 3'h4
  } power_state_t;

  power_state_t pmState;
  power_state_t next_pmState;
  logic [SettleCountWidth-1:0] exitCount;
  logic [SettleCountWidth-1:0] next_exitCount;

  always_comb begin
    next_pmState = pmState;
    next_exitCount = exitCount;
    unique case (pmState)
      PM_ACTIVE: begin
        if (deepSleep) begin
          next_pmState = PM_SLEEP;
        end
      end
      PM_SLEEP: begin
        if (wakeRequest) begin
          next_pmState = PM_EXIT;
          next_exitCount = SettleCountWidth'(ExcursionCycles - 1);
        end
      end
      PM_EXIT: begin
        if (exitCount == '0) begin
          next_pmState = PM_ACTIVE;
        end else begin
          next_exitCount = exitCount - 1'b1;
        end
      end
      default: begin
        next_pmState = PM_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n || powerUpClear) begin
      pmState <= PM_ACTIVE; // RL16
      exitCount <= '0;
    end else begin
      pmState <= next_pmState;
      exitCount <= next_exitCount;
    end
  end

  assign deepSleepActive = (pmState == PM_SLEEP);
  // The subsystem clock passes ungated during the excursion window when it comes from the oscillator.
  assign subsystemClockUnmasked =
    (pmState == PM_EXIT) && subsystemClockFromOscillator; // RL14

  a_auto_low_supervisor: assert property (@(posedge clk) disable iff (!rst_n)
    (lowControl.autoControl && !(lowControl.supervisorEnable &&
     lowControl.supervisorLpmKeep && lowControl.supervisorFullPerf) &&
     !powerUpClear)
    |=> lowStates.supervisorDeep == UNIT_OFF)
    else $error("auto supervisor not off"); // RL2

  a_manual_low_keep: assert property (@(posedge clk) disable iff (!rst_n)
    (!lowControl.autoControl && lowControl.supervisorLpmKeep &&
     !powerUpClear)
    |=> lowStates.supervisorDeep == lowStates.supervisorActive)
    else $error("manual supervisor not kept"); // RL1

  a_manual_monitor: assert property (@(posedge clk) disable iff (!rst_n)
    (!lowControl.autoControl && !powerUpClear)
    |=> lowStates.monitorDeep == lowStates.monitorActive)
    else $error("manual monitor not kept"); // RL3

  a_auto_monitor: assert property (@(posedge clk) disable iff (!rst_n)
    (highControl.autoControl && highControl.monitorEnable &&
     !powerUpClear)
    |=> highStates.monitorDeep ==
        ($past(highControl.monitorFullPerf) ? UNIT_NORMAL : UNIT_OFF))
    else $error("auto monitor wrong"); // RL7

  a_low_auto_monitor: assert property (@(posedge clk) disable iff (!rst_n)
    (lowControl.autoControl && lowControl.monitorEnable &&
     !lowControl.monitorFullPerf && !powerUpClear)
    |=> lowStates.monitorDeep == UNIT_OFF)
    else $error("auto low monitor not off"); // RL4

  a_high_sup_off: assert property (@(posedge clk) disable iff (!rst_n)
    (!highControl.supervisorLpmKeep && !powerUpClear)
    |=> highStates.supervisorDeep == UNIT_OFF)
    else $error("high supervisor not off"); // RL6

  a_slow_wake_class: assert property (@(posedge clk) disable iff (!rst_n)
    (lowControl.supervisorEnable && !lowControl.supervisorFullPerf &&
     !powerUpClear) |=> slowWakeup)
    else $error("slow wake not chosen"); // RL5

  a_slow_delay_holds: assert property (@(posedge clk) disable iff (!rst_n)
    (lowControlWrite && !lowControl.supervisorFullPerf) ##1
    (!lowControlWrite)[*8] |-> lowSettleFlag)
    else $error("slow delay ended early"); // RL9

  a_clear_wakes: assert property (@(posedge clk) disable iff (!rst_n)
    powerUpClear |=> pmState == PM_ACTIVE)
    else $error("clear did not recover"); // RL16

endmodule // supply_supervisor_mode_control

// >>> test/tb_supply_supervisor_mode_control.sv
// Self-checking testbench for the supply supervisor mode control block.
// Assumes the package and design files are compiled first; drives all ports.
`timescale 1ns/100ps
module tb_supply_supervisor_mode_control;
  import supervisor_pkg::*;
  localparam int Slow = 40;
  localparam int Fast = 8;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic powerUpClear = 1'b0;
  side_control_t lowControl = '0;
  side_control_t highControl = '0;
  logic lowControlWrite = 1'b0;
  logic highControlWrite = 1'b0;
  logic deepSleep = 1'b0;
  logic wakeRequest = 1'b0;
  logic subsystemClockFromOscillator = 1'b0;
  side_states_t lowStates;
  side_states_t highStates;
  logic slowWakeup;
  logic lowSettleFlag;
  logic highSettleFlag;
  logic deepSleepActive;
  logic subsystemClockUnmasked;
  int nFail = 0;
  int testsRun = 0;

  supply_supervisor_mode_control #(.SlowCycles(Slow), .FastCycles(Fast))
      u_supply_supervisor_mode_control (
    .clk(clk), .rst_n(rst_n), .powerUpClear(powerUpClear),
    .lowControl(lowControl), .highControl(highControl),
    .lowControlWrite(lowControlWrite), .highControlWrite(highControlWrite),
    .deepSleep(deepSleep), .wakeRequest(wakeRequest),
    .subsystemClockFromOscillator(subsystemClockFromOscillator),
    .lowStates(lowStates), .highStates(highStates),
    .slowWakeup(slowWakeup), .lowSettleFlag(lowSettleFlag),
    .highSettleFlag(highSettleFlag), .deepSleepActive(deepSleepActive),
    .subsystemClockUnmasked(subsystemClockUnmasked));

  always #2.5 clk = ~clk;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    testsRun++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  function automatic unit_state_t act(logic en, logic fp);
    return en ? (fp ? UNIT_FULL : UNIT_NORMAL) : UNIT_OFF;
  endfunction

  function automatic side_states_t want_states(side_control_t c);
    side_states_t s;
    s.supervisorActive = act(c.supervisorEnable, c.supervisorFullPerf);
    s.monitorActive = act(c.monitorEnable, c.monitorFullPerf);
    if (c.autoControl) begin
      s.supervisorDeep = (c.supervisorEnable && c.supervisorLpmKeep &&
                          c.supervisorFullPerf) ? UNIT_NORMAL : UNIT_OFF;
      s.monitorDeep = (c.monitorEnable && c.monitorFullPerf) ?
                      UNIT_NORMAL : UNIT_OFF;
    end else begin
      s.supervisorDeep = c.supervisorLpmKeep ? s.supervisorActive : UNIT_OFF;
      s.monitorDeep = s.monitorActive;
    end
    return s;
  endfunction

  // Writes one side with the given speed; pre > 0 writes once more first.
  task automatic settle(input bit high, input logic fp, input int pre);
    int n;
    n = fp ? Fast : Slow;
    lowControl = '0;
    highControl = '0;
    lowControl.supervisorFullPerf = fp;
    highControl.supervisorFullPerf = fp;
    if (pre > 0) begin
      if (high) highControlWrite = 1'b1; else lowControlWrite = 1'b1;
      @(negedge clk);
      {lowControlWrite, highControlWrite} = 2'b00;
      repeat (pre) @(negedge clk);
    end
    if (high) highControlWrite = 1'b1; else lowControlWrite = 1'b1;
    @(negedge clk);
    {lowControlWrite, highControlWrite} = 2'b00;
    chk(high ? highSettleFlag : lowSettleFlag, 8'h01, "flag set");
    repeat (n - 1) @(negedge clk);
    chk(high ? highSettleFlag : lowSettleFlag, 8'h01, "flag held");
    @(negedge clk);
    chk(high ? highSettleFlag : lowSettleFlag, 8'h00, "flag clear");
  endtask

  // Sleeps and wakes; checks the unmasked window of the subsystem clock.
  task automatic sleep_wake(input logic osc);
    while (lowSettleFlag || highSettleFlag) begin
      @(negedge clk);
    end
    subsystemClockFromOscillator = osc;
    deepSleep = 1'b1;
    @(negedge clk);
    deepSleep = 1'b0;
    chk(deepSleepActive, 8'h01, "sleep entered");
    wakeRequest = 1'b1;
    @(negedge clk);
    wakeRequest = 1'b0;
    chk(deepSleepActive, 8'h00, "woken");
    chk(subsystemClockUnmasked, {7'h00, osc}, "unmasked start");
    repeat (ExcursionCycles - 1) @(negedge clk);
    chk(subsystemClockUnmasked, {7'h00, osc}, "unmasked end");
    @(negedge clk);
    chk(subsystemClockUnmasked, 8'h00, "masked again");
  endtask

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    repeat (10) @(negedge clk);
    chk({lowSettleFlag, highSettleFlag, deepSleepActive, slowWakeup},
        8'h00, "reset outputs");
    rst_n = 1'b1;
    $display("test reset done");
    for (int i = 0; i < 64; i++) begin
      lowControl = side_control_t'(i[5:0]);
      highControl = side_control_t'(~i[5:0]);
      @(negedge clk);
      chk(lowStates, want_states(lowControl), "low map");
      chk(highStates, want_states(highControl), "high map");
      chk(slowWakeup, {7'h00, (lowControl.supervisorEnable &&
          !lowControl.supervisorFullPerf) || (lowControl.monitorEnable &&
          !lowControl.monitorFullPerf)}, "wake class");
    end
    $display("test mapping done");
    settle(1'b0, 1'b1, 0);
    settle(1'b0, 1'b0, 0);
    settle(1'b1, 1'b1, 0);
    settle(1'b1, 1'b0, 5);
    settle(1'b0, 1'b0, 20);
    $display("test settle done");
    sleep_wake(1'b1);
    sleep_wake(1'b0);
    $display("test sleep done");
    deepSleep = 1'b1;
    @(negedge clk);
    deepSleep = 1'b0;
    chk(deepSleepActive, 8'h01, "sleep before clear");
    powerUpClear = 1'b1;
    @(negedge clk);
    powerUpClear = 1'b0;
    chk(deepSleepActive, 8'h00, "clear leaves sleep");
    lowControlWrite = 1'b1;
    @(negedge clk);
    lowControlWrite = 1'b0;
    chk(lowSettleFlag, 8'h01, "flag set before reset");
    rst_n = 1'b0;
    @(negedge clk);
    chk(lowSettleFlag, 8'h00, "reset clears flag");
    rst_n = 1'b1;
    $display("test clear done");
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk);
    nFail++;
    $display("unexpected at %0t: run did not finish", $time);
    print_verdict();
  end
endmodule // tb_supply_supervisor_mode_control
